// file: core/css_pkg.sv
// constants, register map and state codes of the clock source start-up block
// assumes a single 100 MHz fabric clock; oscillators arrive as sampled levels
package css_pkg;

  // ---------------------------------------------------------------
  // clocks
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ   = 100_000_000;
  localparam int unsigned WDT_KHZ  = 128;
  localparam logic [9:0]  WDT_DIV  = 10'(CLK_HZ / (WDT_KHZ * 1000));

  // ---------------------------------------------------------------
  // times in microseconds and counts
  // ---------------------------------------------------------------
  localparam int unsigned T_4P1_US = 4100;
  localparam int unsigned T_65_US  = 65000;
  localparam int unsigned T_4_US   = 4000;
  localparam int unsigned T_64_US  = 64000;
  localparam logic [15:0] MS4P1_TICKS = 16'((T_4P1_US * WDT_KHZ + 999) / 1000);
  localparam logic [15:0] MS4_TICKS   = 16'((T_4_US * WDT_KHZ + 999) / 1000);
  localparam int unsigned MS65_TICKS  = (T_65_US * WDT_KHZ + 999) / 1000;
  localparam int unsigned MS64_TICKS  = (T_64_US * WDT_KHZ + 999) / 1000;
  localparam logic [15:0] RESET_CK     = 16'd14;
  localparam logic [15:0] WAKE_SHORT   = 16'd6;
  localparam logic [15:0] LF_FAST_WAKE = 16'd1024;
  localparam int unsigned LF_SLOW_WAKE = 32768;

  // ---------------------------------------------------------------
  // fuse codes
  // ---------------------------------------------------------------
  localparam logic [3:0] SEL_EXT     = 4'h0;
  localparam logic [3:0] SEL_RC      = 4'h2;
  localparam logic [3:0] SEL_128K    = 4'h3;
  localparam logic [2:0] SEL_LF_HIGH = 3'h2;
  localparam logic [1:0] SUT_SHORT   = 2'h0;
  localparam logic [1:0] SUT_FAST    = 2'h1;
  localparam logic [1:0] SUT_SLOW    = 2'h2;
  localparam logic [3:0] FACTORY_SEL  = 4'h2;
  localparam logic [1:0] FACTORY_SUT  = 2'h2;
  localparam logic       FACTORY_DIV8 = 1'b1;

  // ---------------------------------------------------------------
  // rc oscillator model: phase step = base + trim * step
  // ---------------------------------------------------------------
  localparam logic [31:0] RC_INC_BASE = 32'h12b0_29c4;
  localparam logic [31:0] RC_INC_STEP = 32'h0002_0e58;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0]  TRIM_IDX   = 8'h66;
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_CTRL   = 12'h004;
  localparam logic [11:0] REG_TRIM   = {2'h0, TRIM_IDX, 2'h0};
  localparam logic [7:0]  TRIM_RESET = 8'h00;

  typedef enum logic [5:0] {
    ST_RST_MS = 6'h01,
    ST_RST_CK = 6'h02,
    ST_RUN    = 6'h04,
    ST_SLEEP  = 6'h08,
    ST_WAKE   = 6'h10,
    ST_BAD    = 6'h20
  } css_state_t;

endpackage

// file: core/css_rc_osc.sv
// model of the trimmable internal rc oscillator as a phase accumulator
// assumes i_mclk at 100 MHz; o_tick marks one rc clock cycle
`timescale 1ns/1ps
`default_nettype none
module css_rc_osc (
  input  wire logic       i_mclk,
  input  wire logic       i_reset_n,
  input  wire logic [7:0] i_trim,
  output logic            o_tick
);

  logic [31:0] acc_reg;
  logic [31:0] inc;
  logic [32:0] sum;

  // ---------------------------------------------------------------
  // phase step follows the trim value
  // ---------------------------------------------------------------
  assign inc = css_pkg::RC_INC_BASE + 32'({24'h0, i_trim} * css_pkg::RC_INC_STEP);
  assign sum = {1'b0, acc_reg} + {1'b0, inc};

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      acc_reg <= 32'h0;
      o_tick  <= 1'b0;
    end else begin
      acc_reg <= sum[31:0];
      o_tick  <= sum[32];
    end
  end

endmodule
`default_nettype wire

// file: core/css_wdt_osc.sv
// free running watchdog oscillator tick, independent of the system source
// assumes i_mclk at 100 MHz
`timescale 1ns/1ps
`default_nettype none
module css_wdt_osc (
  input  wire logic i_mclk,
  input  wire logic i_reset_n,
  output logic      o_tick
);

  logic [9:0] div_reg;

  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      div_reg <= 10'h000;
      o_tick  <= 1'b0;
    end else if (div_reg == css_pkg::WDT_DIV - 10'h001) begin
      div_reg <= 10'h000;
      o_tick  <= 1'b1;
    end else begin
      div_reg <= div_reg + 10'h001;
      o_tick  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: core/css_top.sv
// clock source selection and start-up delay sequencer with ahb-lite registers
// assumes oscillator levels and fuse inputs are synchronous to i_mclk
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module css_top #(
  parameter int unsigned P_LF_SLOW_WAKE = css_pkg::LF_SLOW_WAKE,
  parameter int unsigned P_MS65_TICKS   = css_pkg::MS65_TICKS,
  parameter int unsigned P_MS64_TICKS   = css_pkg::MS64_TICKS
) (
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic [3:0]  i_clock_source_select_fuses,
  input  wire logic [1:0]  i_startup_time_fuses,
  input  wire logic        i_divide_by_eight_fuse,
  input  wire logic        i_use_factory_fuses,
  input  wire logic [7:0]  i_factory_cal,
  input  wire logic        i_external_clock_input,
  input  wire logic        i_timer_osc_pin,
  input  wire logic        i_osc128_clk,
  input  wire logic        i_wake_event,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic [31:0]      o_hrdata,
  output logic             o_hresp,
  output logic             o_sys_clk_en,
  output logic             o_clock_ready,
  output logic             o_config_error,
  output logic [7:0]       o_rc_trim,
  output logic             o_wdt_tick
);

  css_pkg::css_state_t state_reg;
  logic [3:0]  sel_reg;
  logic [1:0]  sut_reg;
  logic        div8_reg;
  logic [7:0]  trim_reg;
  logic [15:0] cnt_reg;
  logic [2:0]  div_reg;
  logic        ext_prev_reg;
  logic        lf_prev_reg;
  logic        k128_prev_reg;
  logic        sleep_req_reg;
  logic        wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic        rc_tick;
  logic        wdt_tick;
  logic        src_tick;
  logic        sys_tick;
  logic        cfg_bad;
  logic [15:0] ms_target;
  logic [15:0] wake_target;
  logic        take;
  logic [31:0] rd_mux;
  logic [7:0]  trim_view;

  // ---------------------------------------------------------------
  // oscillators
  // ---------------------------------------------------------------
  css_rc_osc u_rc (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_trim    (trim_reg),
    .o_tick    (rc_tick)
  );

  css_wdt_osc u_wdt (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .o_tick    (wdt_tick)
  );

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_wdt_tick <= 1'b0;
    end else begin
      o_wdt_tick <= wdt_tick;
    end
  end

  // ---------------------------------------------------------------
  // fuse capture while reset is held
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      if (i_use_factory_fuses) begin
        sel_reg  <= css_pkg::FACTORY_SEL;
        sut_reg  <= css_pkg::FACTORY_SUT;
        div8_reg <= css_pkg::FACTORY_DIV8;
      end else begin
        sel_reg  <= i_clock_source_select_fuses;
        sut_reg  <= i_startup_time_fuses;
        div8_reg <= i_divide_by_eight_fuse;
      end
    end
  end

  // ---------------------------------------------------------------
  // source edge detection and selection
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      ext_prev_reg  <= 1'b0;
      lf_prev_reg   <= 1'b0;
      k128_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg  <= i_external_clock_input;
      lf_prev_reg   <= i_timer_osc_pin;
      k128_prev_reg <= i_osc128_clk;
    end
  end

  always_comb begin
    src_tick    = 1'b0;
    cfg_bad     = (sut_reg == 2'h3);
    ms_target   = 16'h0;
    wake_target = css_pkg::WAKE_SHORT;
    case (sut_reg)
      css_pkg::SUT_FAST: ms_target = css_pkg::MS4P1_TICKS;
      css_pkg::SUT_SLOW: ms_target = 16'(P_MS65_TICKS);
      default:           ms_target = 16'h0;
    endcase
    if (sel_reg == css_pkg::SEL_EXT) begin
      src_tick = i_external_clock_input && !ext_prev_reg;
    end else if (sel_reg == css_pkg::SEL_RC) begin
      src_tick = rc_tick;
    end else if (sel_reg == css_pkg::SEL_128K) begin
      src_tick = i_osc128_clk && !k128_prev_reg;
      if (sut_reg == css_pkg::SUT_FAST) begin
        ms_target = css_pkg::MS4_TICKS;
      end else if (sut_reg == css_pkg::SUT_SLOW) begin
        ms_target = 16'(P_MS64_TICKS);
      end
    end else if (sel_reg[3:1] == css_pkg::SEL_LF_HIGH) begin
      src_tick = i_timer_osc_pin && !lf_prev_reg;
      wake_target = sel_reg[0] ? 16'(P_LF_SLOW_WAKE) : css_pkg::LF_FAST_WAKE;
    end else begin
      cfg_bad = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // divide by eight
  // ---------------------------------------------------------------
  assign sys_tick = src_tick && (!div8_reg || div_reg == 3'h7);

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      div_reg <= 3'h0;
    end else if (src_tick) begin
      div_reg <= div_reg + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // start-up sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      state_reg <= css_pkg::ST_RST_MS;
      cnt_reg   <= 16'h0;
    end else begin
      case (state_reg)
        css_pkg::ST_RST_MS: begin
          if (cfg_bad) begin
            state_reg <= css_pkg::ST_BAD;
          end else if (ms_target == 16'h0) begin
            state_reg <= css_pkg::ST_RST_CK;
            cnt_reg   <= 16'h0;
          end else if (wdt_tick) begin
            if (cnt_reg == ms_target - 16'h1) begin
              state_reg <= css_pkg::ST_RST_CK;
              cnt_reg   <= 16'h0;
            end else begin
              cnt_reg <= cnt_reg + 16'h1;
            end
          end
        end
        css_pkg::ST_RST_CK: begin
          if (src_tick) begin
            if (cnt_reg == css_pkg::RESET_CK - 16'h1) begin
              state_reg <= css_pkg::ST_RUN;
              cnt_reg   <= 16'h0;
            end else begin
              cnt_reg <= cnt_reg + 16'h1;
            end
          end
        end
        css_pkg::ST_RUN: begin
          if (sleep_req_reg) begin
            state_reg <= css_pkg::ST_SLEEP;
          end
        end
        css_pkg::ST_SLEEP: begin
          if (i_wake_event) begin
            state_reg <= css_pkg::ST_WAKE;
            cnt_reg   <= 16'h0;
          end
        end
        css_pkg::ST_WAKE: begin
          if (src_tick) begin
            if (cnt_reg == wake_target - 16'h1) begin
              state_reg <= css_pkg::ST_RUN;
              cnt_reg   <= 16'h0;
            end else begin
              cnt_reg <= cnt_reg + 16'h1;
            end
          end
        end
        css_pkg::ST_BAD: begin
          state_reg <= css_pkg::ST_BAD;
        end
        default: begin
          state_reg <= css_pkg::ST_BAD;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_sys_clk_en   <= 1'b0;
      o_clock_ready  <= 1'b0;
      o_config_error <= 1'b0;
    end else begin
      o_sys_clk_en   <= (state_reg == css_pkg::ST_RUN) && sys_tick;
      o_clock_ready  <= (state_reg == css_pkg::ST_RUN);
      o_config_error <= (state_reg == css_pkg::ST_BAD);
    end
  end

  // ---------------------------------------------------------------
  // ahb-lite slave
  // ---------------------------------------------------------------
  assign take      = i_hsel && i_hready && i_htrans[1];
  assign trim_view = (wr_pend_reg && wr_addr_reg == css_pkg::REG_TRIM) ? i_hwdata[7:0]
                                                                        : trim_reg;

  always_comb begin
    case (i_haddr[11:0])
      css_pkg::REG_STATUS: rd_mux = {16'h0, o_clock_ready, div8_reg, sut_reg, sel_reg,
                                     2'h0, state_reg};
      css_pkg::REG_CTRL:   rd_mux = {31'h0, sleep_req_reg};
      css_pkg::REG_TRIM:   rd_mux = {24'h0, trim_view};
      default:             rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      o_hrdata    <= 32'h0;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      wr_pend_reg <= take && i_hwrite;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      if (take) begin
        wr_addr_reg <= i_haddr[11:0];
      end
      o_hrdata <= (take && !i_hwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      trim_reg <= i_factory_cal;
    end else if (wr_pend_reg && wr_addr_reg == css_pkg::REG_TRIM) begin
      trim_reg <= i_hwdata[7:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      sleep_req_reg <= 1'b0;
    end else if (wr_pend_reg && wr_addr_reg == css_pkg::REG_CTRL) begin
      sleep_req_reg <= i_hwdata[0];
    end else begin
      sleep_req_reg <= 1'b0;
    end
  end

  assign o_rc_trim = trim_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  a_wake_exit_count: assert property (
    (state_reg == css_pkg::ST_RUN) && $past(state_reg) == css_pkg::ST_WAKE
      |-> $past(cnt_reg) == $past(wake_target) - 16'h1 && $past(src_tick))
    else $error("wake ended early");
  a_ms_exit_count: assert property (
    $past(state_reg) == css_pkg::ST_RST_MS && state_reg == css_pkg::ST_RST_CK
      |-> $past(ms_target) == 16'h0 || ($past(wdt_tick) && $past(cnt_reg) == $past(ms_target) - 16'h1))
    else $error("millisecond delay cut short");
  a_ck_exit_count: assert property (
    $past(state_reg) == css_pkg::ST_RST_CK && state_reg == css_pkg::ST_RUN
      |-> $past(cnt_reg) == css_pkg::RESET_CK - 16'h1 && $past(src_tick))
    else $error("reset cycle delay wrong");
  a_rc_source_sel: assert property (
    sel_reg == css_pkg::SEL_RC |-> src_tick == rc_tick)
    else $error("rc tick not selected");
  a_div8_spacing: assert property (
    div8_reg && o_sys_clk_en |=> !o_sys_clk_en [*7])
    else $error("divided clock too fast");
  a_trim_reset_load: assert property (
    $past(!i_reset_n) |-> trim_reg == $past(i_factory_cal))
    else $error("trim not loaded at reset");
  a_trim_follow: assert property (
    wr_pend_reg && wr_addr_reg == css_pkg::REG_TRIM |=> o_rc_trim == $past(i_hwdata[7:0]))
    else $error("trim write lost");
  a_wdt_period: assert property (
    o_wdt_tick |=> !o_wdt_tick [*8])
    else $error("watchdog tick too fast");
  a_bad_config: assert property (
    cfg_bad && state_reg == css_pkg::ST_RST_MS |=> state_reg == css_pkg::ST_BAD ##1 o_config_error)
    else $error("bad config not trapped");
  a_run_gate: assert property (
    o_sys_clk_en |-> $past(state_reg) == css_pkg::ST_RUN)
    else $error("clock released before run");

  c_reach_run: cover property (state_reg == css_pkg::ST_RUN);
  c_sleep_wake: cover property (state_reg == css_pkg::ST_SLEEP ##1 state_reg == css_pkg::ST_WAKE);
  c_trim_write: cover property (wr_pend_reg && wr_addr_reg == css_pkg::REG_TRIM);
  c_bad_state: cover property (o_config_error);

endmodule
`default_nettype wire

// file: tb/css_osc_model.sv
// free running models of the external clock, crystal and 128 kHz oscillator levels
// assumes i_mclk at 100 MHz; levels change only on its rising edge
`timescale 1ns/1ps
`default_nettype none
module css_osc_model (
  input  wire logic i_mclk,
  input  wire logic i_slow,
  output logic      o_ext_clk,
  output logic      o_lf_clk,
  output logic      o_k128_clk
);
  // ---------------------------------------------------------------
  // half period counters
  // ---------------------------------------------------------------
  logic [4:0] ext_cnt;
  logic [4:0] lf_cnt;
  logic [4:0] k128_cnt;
  logic [4:0] ext_half;

  assign ext_half = i_slow ? 5'h05 : 5'h02;

  initial begin
    ext_cnt = 5'h00;
    lf_cnt = 5'h00;
    k128_cnt = 5'h00;
    o_ext_clk = 1'b0;
    o_lf_clk = 1'b0;
    o_k128_clk = 1'b0;
  end

  // external source drives its input: period 6, or 12 when slow
  always @(posedge i_mclk) begin
    ext_cnt <= (ext_cnt >= ext_half) ? 5'h00 : ext_cnt + 5'h01;
    if (ext_cnt >= ext_half) o_ext_clk <= ~o_ext_clk;
  end

  // crystal period 20, 128 kHz period 10
  always @(posedge i_mclk) begin
    lf_cnt <= (lf_cnt == 5'h09) ? 5'h00 : lf_cnt + 5'h01;
    if (lf_cnt == 5'h09) o_lf_clk <= ~o_lf_clk;
    k128_cnt <= (k128_cnt == 5'h04) ? 5'h00 : k128_cnt + 5'h01;
    if (k128_cnt == 5'h04) o_k128_clk <= ~o_k128_clk;
  end
endmodule
`default_nettype wire

// file: tb/clock_source_startup_select_bench.sv
// self-checking bench of the clock source start-up sequencer
// assumes css_top with short ms and slow wake counts, oscillators from css_osc_model
`timescale 1ns/1ps
`default_nettype none
module clock_source_startup_select_bench;
  typedef struct {logic [3:0] s; logic [1:0] t; logic d; int p; int mt; int we;} css_row_t;
  logic        clk = 0, rst_n = 0, fac = 0, slow = 0, wake = 0, hwr = 0, div8 = 0;
  logic [3:0]  sel = 0;
  logic [1:0]  startup_time_fuses = 0, htr = 0;
  logic [7:0]  cal = 8'h80, trim;
  logic [31:0] hadr = 0, hwd = 0, rd, last_rd, hrd;
  logic        ext, lf, k128, hrdy, sce, crdy, cerr, hresp, wtick, last_rdy;
  int          bad_count = 0, n_tests = 0, n, i, nl;
  // lf rows use the 1K options only where start-up stability does not matter
  css_row_t rows[8] = '{'{4'h0, 2'h0, 1'b0, 6, 0, 6}, '{4'h2, 2'h0, 1'b1, 13, 0, 6},
    '{4'h3, 2'h2, 1'b0, 10, 5, 6}, '{4'h5, 2'h0, 1'b0, 20, 0, 40},
    '{4'h4, 2'h2, 1'b1, 20, 5, 1024}, '{4'h0, 2'h3, 1'b0, 0, 0, 0},
    '{4'h1, 2'h0, 1'b0, 0, 0, 0}, '{4'h0, 2'h2, 1'b1, 6, 5, 6}};

  css_osc_model u_css_osc_model (.i_mclk(clk), .i_slow(slow), .o_ext_clk(ext), .o_lf_clk(lf),
    .o_k128_clk(k128));
  css_top #(.P_LF_SLOW_WAKE(40), .P_MS65_TICKS(5), .P_MS64_TICKS(5)) u_css_top (
    .i_mclk(clk), .i_reset_n(rst_n), .i_clock_source_select_fuses(sel),
    .i_startup_time_fuses(startup_time_fuses), .i_divide_by_eight_fuse(div8), .i_use_factory_fuses(fac),
    .i_factory_cal(cal), .i_external_clock_input(ext), .i_timer_osc_pin(lf),
    .i_osc128_clk(k128), .i_wake_event(wake), .i_hsel(1'b1), .i_haddr(hadr), .i_htrans(htr),
    .i_hwrite(hwr), .i_hsize(3'h2), .i_hwdata(hwd), .i_hready(hrdy), .o_hreadyout(hrdy),
    .o_hrdata(hrd), .o_hresp(hresp), .o_sys_clk_en(sce), .o_clock_ready(crdy),
    .o_config_error(cerr), .o_rc_trim(trim), .o_wdt_tick(wtick));

  // ---------------------------------------------------------------
  // clock, bus sampling, watchdog
  // ---------------------------------------------------------------
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    last_rd <= hrd;
    last_rdy <= hrdy;
  end
  initial begin
    repeat (95000) @(posedge clk);
    bad_count++;
    end_of_test();
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_of_test();
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic in_range(input int lo, input int hi);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    htr <= 2'h2;
    hadr <= a;
    hwr <= w;
    do begin @(posedge clk); #1; end while (last_rdy !== 1'b1);
    htr <= 2'h0;
    hwd <= d;
    do begin @(posedge clk); #1; end while (last_rdy !== 1'b1);
    rd = last_rd;
  endtask
  task automatic do_reset(input logic [3:0] s, input logic [1:0] t, input logic d);
    @(posedge clk);
    sel <= s;
    startup_time_fuses <= t;
    div8 <= d;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic wait_rdy();
    n = 0;
    while (crdy !== 1'b1 && cerr !== 1'b1 && n < 30000) begin @(negedge clk); n++; end
  endtask
  task automatic cnt_pulses(input int w);
    n = 0;
    repeat (w) begin @(negedge clk); if (sce === 1'b1) n++; end
  endtask

  // ---------------------------------------------------------------
  // table of source and start-up settings, then hand cases
  // ---------------------------------------------------------------
  initial begin
    for (i = 0; i < 8; i++) begin
      do_reset(rows[i].s, rows[i].t, rows[i].d);
      wait_rdy();
      xfer(1'b0, css_pkg::REG_STATUS, 32'h0);
      if (rows[i].p == 0) begin
        chk(rd[5:0], 6'h20);
        chk(crdy, 1'b0);
        chk(hresp, 1'b0);
      end else begin
        in_range((rows[i].mt > 0 ? (rows[i].mt - 1) * 781 : 0) + 13 * rows[i].p,
          rows[i].mt * 781 + 15 * rows[i].p + 8);
        chk(rd, {16'h0, 1'b1, rows[i].d, rows[i].t, rows[i].s, 2'h0, 6'h04});
        cnt_pulses(960);
        nl = 960 / rows[i].p / (rows[i].d ? 8 : 1);
        in_range(nl - 2, nl + 2);
        xfer(1'b1, css_pkg::REG_CTRL, 32'h1);
        xfer(1'b0, css_pkg::REG_STATUS, 32'h0);
        chk(rd[5:0], 6'h08);
        @(posedge clk) wake <= 1'b1;
        @(posedge clk) wake <= 1'b0;
        wait_rdy();
        in_range((rows[i].we - 1) * rows[i].p, (rows[i].we + 1) * rows[i].p + 8);
      end
    end
    n = 0;
    do begin @(negedge clk); n++; end while (wtick !== 1'b1 && n < 2000);
    n = 0;
    do begin @(negedge clk); n++; end while (wtick !== 1'b1 && n < 2000);
    chk(32'(n), 32'(css_pkg::WDT_DIV));
    cal <= 8'h3c;
    do_reset(4'h2, 2'h0, 1'b0);
    wait_rdy();
    xfer(1'b0, css_pkg::REG_TRIM, 32'h0);
    chk(rd, 32'h3c);
    xfer(1'b1, css_pkg::REG_TRIM, 32'hff);
    xfer(1'b0, css_pkg::REG_TRIM, 32'h0);
    chk(rd, 32'hff);
    chk(trim, 8'hff);
    cnt_pulses(1000);
    nl = n;
    xfer(1'b1, css_pkg::REG_TRIM, 32'h0);
    cnt_pulses(1000);
    in_range(71, 75);
    chk(32'(nl - n >= 5), 32'h1);
    xfer(1'b0, 32'h0f0, 32'h0);
    chk(rd, 32'h0);
    cal <= 8'h5a;
    fac <= 1'b1;
    do_reset(4'hf, 2'h3, 1'b0);
    wait_rdy();
    xfer(1'b0, css_pkg::REG_STATUS, 32'h0);
    chk(rd, {16'h0, 1'b1, 1'b1, 2'h2, 4'h2, 2'h0, 6'h04});
    chk(trim, 8'h5a);
    fac <= 1'b0;
    slow <= 1'b1;
    do_reset(4'h0, 2'h0, 1'b0);
    wait_rdy();
    in_range(13 * 12, 15 * 12 + 8);
    end_of_test();
  end
endmodule
`default_nettype wire
